// ===== eprd_regs.svh
// Purpose : register offsets, field positions and reset values of the pin request detector
// Assumes : apb byte addressing, one aligned word per register
// Notes   : definitions only
`ifndef EPRD_REGS_SVH
`define EPRD_REGS_SVH

`define EPRD_OFF_ENABLE     12'h000
`define EPRD_OFF_EDGE       12'h004
`define EPRD_OFF_STATUS     12'h008
`define EPRD_OFF_PINFUNC    12'h00c
`define EPRD_OFF_IRQ_STAT   12'h010
`define EPRD_OFF_IRQ_MASK   12'h014
`define EPRD_OFF_ACK        12'h018

`define EPRD_RST_BYTE       8'h00
`define EPRD_RST_LINES      6'h00
`define EPRD_RST_EVT        2'h0
`define EPRD_ENABLE_MASK    8'h3f
`define EPRD_EDGE_MASK      8'h7f
`define EPRD_BOTH_BIT       1
`define EPRD_POL0_BIT       0
`define EPRD_VECTOR_BASE    8'h15
`define EPRD_ACK_VALID_BIT  8
`define EPRD_EVT_SET        0
`define EPRD_EVT_CLR        1
`define EPRD_ZERO32         32'h0000_0000

`endif

// ===== eprd_pkg.sv
// Purpose : types of the pin request detector
// Assumes : none
// Notes   : constants live in eprd_regs.svh
package eprd_pkg;
    typedef enum logic [1:0] {
        EPRD_EDGE_FALL = 2'b00,
        EPRD_EDGE_RISE = 2'b01,
        EPRD_EDGE_BOTH = 2'b10
    } eprd_edge_t;
    typedef enum logic [0:0] {
        EPRD_APB_IDLE   = 1'b0,
        EPRD_APB_ACCESS = 1'b1
    } eprd_apb_t;
endpackage : eprd_pkg

// ===== eprd_sync.sv
// Purpose : two-flop synchroniser plus previous-sample register per request pin
// Assumes : reset level of the pins is low for the sample history
// Notes   : first stage is read only by the second
`timescale 1ns/10ps
module eprd_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_q,
    output logic      [WIDTH-1:0] prev_q
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q  <= '0;
            level_q <= '0;
            prev_q  <= '0;
        end else begin
            meta_q  <= pin_in;
            level_q <= meta_q;
            prev_q  <= level_q;
        end
    end
endmodule : eprd_sync

// ===== eprd_edge.sv
// Purpose : per-line edge detection from current and previous samples
// Assumes : line zero may select both edges, other lines one polarity
// Notes   : purely combinational
`timescale 1ns/10ps
`include "eprd_regs.svh"
module eprd_edge #(
    parameter int LINES = 6
) (
    input  wire logic [LINES-1:0] level,
    input  wire logic [LINES-1:0] prev,
    input  wire logic [7:0]       edge_sel,
    output logic      [LINES-1:0] edge_hit
);
    function automatic logic hit(input logic cur, input logic old, input eprd_pkg::eprd_edge_t m);
        logic rise;
        logic fall;
        rise = cur & ~old;
        fall = ~cur & old;
        case (m)
            eprd_pkg::EPRD_EDGE_FALL: hit = fall;
            eprd_pkg::EPRD_EDGE_RISE: hit = rise;
            eprd_pkg::EPRD_EDGE_BOTH: hit = rise | fall;
            default:                  hit = 1'b0;
        endcase
    endfunction : hit

    wire eprd_pkg::eprd_edge_t mode0 = edge_sel[`EPRD_BOTH_BIT] ? eprd_pkg::EPRD_EDGE_BOTH :
        (edge_sel[`EPRD_POL0_BIT] ? eprd_pkg::EPRD_EDGE_RISE : eprd_pkg::EPRD_EDGE_FALL);

    assign edge_hit[0] = hit(level[0], prev[0], mode0);
    for (genvar i = 1; i < LINES; i++) begin : g_line
        assign edge_hit[i] = hit(level[i], prev[i], edge_sel[i+1] ?
            eprd_pkg::EPRD_EDGE_RISE : eprd_pkg::EPRD_EDGE_FALL);
    end
endmodule : eprd_edge

// ===== eprd_top.sv
// Purpose : external pin request detector with apb register access
// Assumes : pins synchronous enough for a two-flop synchroniser, apb slave with zero wait
// Notes   : status flags clear by read-one then write-zero
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "eprd_regs.svh"
module eprd_top #(
    parameter int LINES = 6
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [LINES-1:0] shared_pin_in,
    output logic      [LINES-1:0] port_one_io_pin,
    output logic      [LINES-1:0] line_request,
    output logic                  request_valid,
    output logic      [7:0]       request_vector,
    input  wire logic [LINES-1:0] exception_ack,
    output logic                  irq
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]       request_enable_q;
    logic [7:0]       edge_select_q;
    logic [LINES-1:0] request_status_q;
    logic [LINES-1:0] status_d;
    logic [LINES-1:0] read_one_q;
    logic [LINES-1:0] read_one_d;
    logic [7:0]       port_one_pin_function_q;
    logic [1:0]       evt_stat_q;
    logic [1:0]       evt_stat_d;
    logic [1:0]       evt_mask_q;
    logic [31:0]      prdata_q;
    logic [31:0]      rdata_d;
    eprd_pkg::eprd_apb_t apb_q;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire access   = psel & penable;
    wire wr       = access & pwrite & pstrb[0];
    wire rd       = access & ~pwrite;
    wire sel_en   = paddr == `EPRD_OFF_ENABLE;
    wire sel_edge = paddr == `EPRD_OFF_EDGE;
    wire sel_st   = paddr == `EPRD_OFF_STATUS;
    wire sel_pf   = paddr == `EPRD_OFF_PINFUNC;
    wire sel_is   = paddr == `EPRD_OFF_IRQ_STAT;
    wire sel_im   = paddr == `EPRD_OFF_IRQ_MASK;
    wire sel_ack  = paddr == `EPRD_OFF_ACK;
    wire mapped   = sel_en | sel_edge | sel_st | sel_pf | sel_is | sel_im | sel_ack;

    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata  = prdata_q;

    // ------------------------------------------------------------
    // pin path
    // ------------------------------------------------------------
    logic [LINES-1:0] level_q;
    logic [LINES-1:0] prev_q;
    logic [LINES-1:0] edge_hit;
    logic [LINES-1:0] gated_pin;

    // unselected pins are seen as low; switching may therefore fake an edge
    assign gated_pin = shared_pin_in & port_one_pin_function_q[LINES-1:0];
    assign port_one_io_pin = shared_pin_in & ~port_one_pin_function_q[LINES-1:0];

    eprd_sync #(.WIDTH(LINES)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  (gated_pin),
        .level_q (level_q),
        .prev_q  (prev_q)
    );

    eprd_edge #(.LINES(LINES)) u_edge (
        .level    (level_q),
        .prev     (prev_q),
        .edge_sel (edge_select_q),
        .edge_hit (edge_hit)
    );

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    wire [LINES-1:0] wr_zero  = (wr & sel_st) ? ~pwdata[LINES-1:0] : '0;
    wire [LINES-1:0] clr_mask = (wr_zero & read_one_q) | exception_ack;
    assign status_d = (request_status_q & ~clr_mask) | edge_hit;
    // arm a flag for clearing when it is read as one; a write to the status register disarms all
    assign read_one_d = (rd & sel_st) ? request_status_q :
                        ((wr & sel_st) ? '0 : read_one_q & request_status_q);

    // ------------------------------------------------------------
    // requests and vector
    // ------------------------------------------------------------
    assign line_request  = request_status_q & request_enable_q[LINES-1:0];
    assign request_valid = |line_request;

    function automatic logic [7:0] vec(input logic [LINES-1:0] req);
        vec = `EPRD_RST_BYTE;
        for (int i = LINES - 1; i >= 0; i--) begin
            if (req[i]) begin
                vec = `EPRD_VECTOR_BASE + 8'(i);
            end
        end
    endfunction : vec

    assign request_vector = vec(line_request);

    // ------------------------------------------------------------
    // event interrupt
    // ------------------------------------------------------------
    wire [1:0] evt_in = {|(request_status_q & clr_mask), |(edge_hit)};
    wire [1:0] evt_w1c = (wr & sel_is) ? pwdata[1:0] : `EPRD_RST_EVT;
    assign evt_stat_d = (evt_stat_q & ~evt_w1c) | evt_in;
    assign irq = |(evt_stat_q & evt_mask_q);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = `EPRD_ZERO32;
        if (sel_en)   rdata_d[7:0] = request_enable_q;
        if (sel_edge) rdata_d[7:0] = edge_select_q;
        if (sel_st)   rdata_d[LINES-1:0] = request_status_q;
        if (sel_pf)   rdata_d[7:0] = port_one_pin_function_q;
        if (sel_is)   rdata_d[1:0] = evt_stat_q;
        if (sel_im)   rdata_d[1:0] = evt_mask_q;
        if (sel_ack)  rdata_d[`EPRD_ACK_VALID_BIT:0] = {request_valid, request_vector};
    end

    // ------------------------------------------------------------
    // flops
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            request_enable_q        <= `EPRD_RST_BYTE;
            edge_select_q           <= `EPRD_RST_BYTE;
            request_status_q        <= `EPRD_RST_LINES;
            read_one_q              <= `EPRD_RST_LINES;
            port_one_pin_function_q <= `EPRD_RST_BYTE;
            evt_stat_q              <= `EPRD_RST_EVT;
            evt_mask_q              <= `EPRD_RST_EVT;
            prdata_q                <= `EPRD_ZERO32;
            apb_q                   <= eprd_pkg::EPRD_APB_IDLE;
        end else begin
            request_status_q <= status_d;
            read_one_q       <= read_one_d;
            evt_stat_q       <= evt_stat_d;
            apb_q            <= access ? eprd_pkg::EPRD_APB_ACCESS : eprd_pkg::EPRD_APB_IDLE;
            if (psel & ~penable & ~pwrite) prdata_q <= rdata_d;
            if (wr & sel_en)   request_enable_q <= pwdata[7:0] & `EPRD_ENABLE_MASK;
            if (wr & sel_edge) edge_select_q    <= pwdata[7:0] & `EPRD_EDGE_MASK;
            if (wr & sel_pf)   port_one_pin_function_q <= pwdata[7:0];
            if (wr & sel_im)   evt_mask_q       <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_read_one(int n);
        rd && sel_st && request_status_q[n];
    endsequence

    AST_RESET_ZERO: assert property (@(posedge pclk)
        $rose(presetn) |-> request_enable_q == `EPRD_RST_BYTE && request_status_q == '0)
        else $error("registers not zero after reset");
    AST_ENABLE_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        line_request == (request_status_q & request_enable_q[LINES-1:0]))
        else $error("request not gated by enable");
    AST_EDGE_SETS: assert property (@(posedge pclk) disable iff (!presetn)
        |edge_hit |=> |request_status_q)
        else $error("edge did not set a flag");
    AST_LINE0_BOTH: assert property (@(posedge pclk) disable iff (!presetn)
        edge_select_q[`EPRD_BOTH_BIT] && (level_q[0] != prev_q[0]) |=> request_status_q[0])
        else $error("line zero both-edge missed");
    AST_LINE1_RISE: assert property (@(posedge pclk) disable iff (!presetn)
        edge_select_q[2] && $rose(level_q[1]) |=> request_status_q[1])
        else $error("line one rising edge missed");
    AST_W1_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
        wr && sel_st && pwdata[0] && request_status_q[0] |=> request_status_q[0])
        else $error("writing one cleared a flag");
    AST_NO_READ_NO_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        wr && sel_st && !pwdata[0] && !read_one_q[0] && request_status_q[0]
        && !exception_ack[0] |=> request_status_q[0])
        else $error("flag cleared without prior read");
    AST_READ_ARMS: assert property (@(posedge pclk) disable iff (!presetn)
        s_read_one(0) |=> read_one_q[0])
        else $error("read of a set flag did not arm clearing");
    AST_READ_THEN_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        read_one_q[0] && wr && sel_st && !pwdata[0] && !edge_hit[0] |=> !request_status_q[0])
        else $error("read then zero write did not clear");
    AST_ACK_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        exception_ack[0] && !edge_hit[0] |=> !request_status_q[0])
        else $error("acknowledge did not clear flag");
    AST_VECTOR: assert property (@(posedge pclk) disable iff (!presetn)
        line_request[0] |-> request_vector == `EPRD_VECTOR_BASE)
        else $error("line zero vector wrong");
    AST_SYNC_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(gated_pin[2]) ##1 gated_pin[2] |=> level_q[2])
        else $error("synchroniser latency wrong");
endmodule : eprd_top

// ===== eprd_pin_model.sv
// Purpose : external request sources driving the six request pins
// Assumes : sources always drive a clean high or low level
// Notes   : levels change just after a rising clock edge
`timescale 1ns/10ps
module eprd_pin_model (
    input  wire logic       pclk,
    output logic      [5:0] pins
);
    // ----------------------------------------
    // pin driver
    // ----------------------------------------
    initial pins = 6'h00;

    // hold each new level long enough to pass the synchroniser
    task automatic set_pins(input logic [5:0] v);
        @(posedge pclk);
        pins <= v;
        repeat (6) @(posedge pclk);
    endtask : set_pins
endmodule : eprd_pin_model

// ===== external_pin_request_detect_tb_top.sv
// Purpose : self-checking bench of the pin request detector
// Assumes : zero-wait apb slave, flags visible three cycles after a pin change
// Notes   : reads are noted in a queue and compared by a monitor
`timescale 1ns/10ps
module external_pin_request_detect_tb_top;
    logic        pclk          = 1'b0;
    logic        presetn       = 1'b0;
    logic        psel          = 1'b0;
    logic        penable       = 1'b0;
    logic        pwrite        = 1'b0;
    logic [11:0] paddr         = 12'h000;
    logic [31:0] pwdata        = 32'h0;
    logic [3:0]  pstrb         = 4'hf;
    logic [5:0]  exception_ack = 6'h00;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        request_valid;
    logic        irq;
    logic [5:0]  pins;
    logic [5:0]  port_one_io_pin;
    logic [5:0]  line_request;
    logic [7:0]  request_vector;
    logic [63:0] notes[$];
    logic [31:0] seed          = 32'h34;
    logic [31:0] v;
    logic [11:0] aoff[3]       = '{12'h000, 12'h004, 12'h00c};
    logic [31:0] msk[3]        = '{32'h3f, 32'h7f, 32'hff};
    int          n_mismatch    = 0;
    int          num_checks    = 0;

    eprd_top #(.LINES(6)) u_eprd_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .shared_pin_in(pins), .port_one_io_pin(port_one_io_pin),
        .line_request(line_request), .request_valid(request_valid),
        .request_vector(request_vector), .exception_ack(exception_ack), .irq(irq)
    );
    eprd_pin_model u_eprd_pin_model (.pclk(pclk), .pins(pins));

    always #2 pclk = ~pclk;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] next_rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : next_rnd

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic err);
        @(posedge pclk);
        if (!w) notes.push_back({m, d});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : 32'h0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        chk("pslverr", {31'h0, err}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, e, 32'hffff_ffff, 1'b0);
    endtask : rd

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // read monitor
    // ----------------------------------------
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
            chk("prdata", notes[0][31:0] & notes[0][63:32], prdata & notes[0][63:32]);
            void'(notes.pop_front());
        end
    end

    initial begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        final_report();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) rd(12'(4 * i), 32'h0);
        pstrb <= 4'he;
        wr(12'h000, 32'h3f);
        pstrb <= 4'hf;
        rd(12'h000, 32'h0);
        for (int i = 0; i < 3; i++) begin
            v = next_rnd() & msk[i];
            wr(aoff[i], v);
            rd(aoff[i], v);
        end
        wr(12'h000, 32'h3f);
        wr(12'h00c, 32'h3f);
        wr(12'h004, 32'h7d);
        u_eprd_pin_model.set_pins(6'h3f);
        rd(12'h008, 32'h3f);
        @(negedge pclk);
        chk("line_request", 32'h3f, {26'h0, line_request});
        chk("request_vector", 32'h15, {24'h0, request_vector});
        wr(12'h008, 32'h3f);
        wr(12'h008, 32'h00);
        rd(12'h008, 32'h3f);
        wr(12'h008, 32'h3e);
        rd(12'h008, 32'h3e);
        @(posedge pclk);
        exception_ack <= 6'h02;
        @(posedge pclk);
        exception_ack <= 6'h00;
        rd(12'h008, 32'h3c);
        wr(12'h000, 32'h2b);
        @(negedge pclk);
        chk("line_request", 32'h28, {26'h0, line_request});
        chk("request_vector", 32'h18, {24'h0, request_vector});
        wr(12'h004, 32'h00);
        u_eprd_pin_model.set_pins(6'h00);
        rd(12'h008, 32'h3f);
        wr(12'h008, 32'h00);
        rd(12'h008, 32'h00);
        wr(12'h004, 32'h02);
        u_eprd_pin_model.set_pins(6'h01);
        rd(12'h008, 32'h01);
        wr(12'h008, 32'h00);
        u_eprd_pin_model.set_pins(6'h00);
        rd(12'h008, 32'h01);
        wr(12'h008, 32'h00);
        wr(12'h000, 32'h00);
        wr(12'h00c, 32'h3e);
        u_eprd_pin_model.set_pins(6'h01);
        @(negedge pclk);
        chk("port_one_io_pin", 32'h1, {31'h0, port_one_io_pin[0]});
        wr(12'h004, 32'h01);
        wr(12'h00c, 32'h3f);
        repeat (6) @(posedge pclk);
        rd(12'h008, 32'h01);
        wr(12'h008, 32'h00);
        rd(12'h008, 32'h00);
        wr(12'h000, 32'h3f);
        wr(12'h014, 32'h01);
        @(negedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(12'h014, 32'h00);
        @(negedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        wr(12'h014, 32'h01);
        wr(12'h010, 32'h03);
        @(negedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b0, 12'h020, 32'h0, 32'hffff_ffff, 1'b1);
        repeat (2) @(posedge pclk);
        final_report();
    end
endmodule : external_pin_request_detect_tb_top
